/* File: logic/read_sync_defs.vh */
// Purpose: register map, reset values and count defaults for the data separator
// Assumes: AHB-Lite word registers, counts in cycles of hclk (10 MHz, 100 ns)
// Notes:   all timing counts below are hclk cycles unless named otherwise
`ifndef READ_SYNC_DEFS_VH
`define READ_SYNC_DEFS_VH

// ============================================================
// register byte offsets
`define OFS_LOOP_HALF      8'h00
`define OFS_QCELL          8'h04
`define OFS_STEADY_SET     8'h08
`define OFS_NOMINAL        8'h0c
`define OFS_SHIFT_SET      8'h10
`define OFS_PULSE_WIDTH    8'h14
`define OFS_STATUS         8'h18

// ============================================================
// status register fields
`define ST_READ_SELECT     0
`define ST_STEADY          1
`define ST_LOOP_STOPPED    2
`define ST_READ_CLOCK      3

// ============================================================
// reset values of the count registers
`define RST_LOOP_HALF      16'h0004
`define RST_QCELL          16'h0002
`define RST_STEADY_SET     16'h000c
`define RST_NOMINAL        16'h0004
`define RST_SHIFT_SET      16'h0001
`define RST_PULSE_WIDTH    16'h0002

// ============================================================
// timing: read clock period is four loop half periods
`define RCLK_HALVES        4
`define STOP_RCLK_MAX      3
`define SYNC_RCLK_MAX      2

`endif

/* File: logic/read_sync_write_precomp.v */
// Purpose: digital data separator and write precompensation, sampled on hclk
// Assumes: all pins synchronous to hclk; registers over AHB-Lite, zero wait
// Notes:   the loop oscillator is a reloadable half-period counter
//
// The register offsets and the AHB-Lite slave port were decided locally.
`timescale 1ns/10ps
`include "read_sync_defs.vh"

module read_sync_write_precomp #(
	parameter CW = 16
) (
	input  wire        hclk,
	input  wire        hresetn,
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg  [31:0] hrdata,
	output wire        hreadyout,
	output wire        hresp,
	input  wire        osc_in,
	output reg         osc_out,
	input  wire        encoded_read_in,
	input  wire        read_select,
	output reg         read_clock,
	output reg         retimed_read_data,
	output reg         steady_pattern_flag,
	input  wire        encoded_write_in,
	input  wire        shift_enable,
	input  wire        early_n,
	input  wire        late_n,
	output reg         write_clock,
	output reg         comp_write_data
);

	localparam LOOP_RUN  = 1'b0;
	localparam LOOP_STOP = 1'b1;
	// forces any count to at least one cycle
	function [CW-1:0] at_least_one;
		input [CW:0] v;
		begin
			if (v[CW] || v[CW-1:0] == {CW{1'b0}})
				at_least_one = {{(CW-1){1'b0}}, 1'b1};
			else
				at_least_one = v[CW-1:0];
		end
	endfunction
	// ============================================================
	// AHB-Lite slave
	reg  [CW-1:0] loop_half;
	reg  [CW-1:0] qcell;
	reg  [CW-1:0] steady_timer_set;
	reg  [CW-1:0] nominal_delay;
	reg  [CW-1:0] shift_amount_set;
	reg  [CW-1:0] pulse_width;
	reg           wr_pend;
	reg  [7:0]    wr_addr;
	reg           loop_state;
	reg           vco;
	wire          take = hsel & hready & htrans[1];
	assign hreadyout = 1'b1;  // every access finishes in one data phase
	assign hresp     = 1'b0;
	// address phase latch and read data register
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
			hrdata  <= 32'h00000000;
		end
		else
		begin
			wr_pend <= take & hwrite;
			wr_addr <= haddr[7:0];
			if (take && !hwrite)
			begin
				case (haddr[7:0])
				`OFS_LOOP_HALF:   hrdata <= {{(32-CW){1'b0}}, loop_half};
				`OFS_QCELL:       hrdata <= {{(32-CW){1'b0}}, qcell};
				`OFS_STEADY_SET:  hrdata <= {{(32-CW){1'b0}}, steady_timer_set};
				`OFS_NOMINAL:     hrdata <= {{(32-CW){1'b0}}, nominal_delay};
				`OFS_SHIFT_SET:   hrdata <= {{(32-CW){1'b0}}, shift_amount_set};
				`OFS_PULSE_WIDTH: hrdata <= {{(32-CW){1'b0}}, pulse_width};
				`OFS_STATUS:      hrdata <= {28'h0000000, read_clock, loop_state,
				                             steady_pattern_flag, read_select};
				default:          hrdata <= 32'h00000000;
				endcase
			end
		end
	end
	// count registers; unmapped writes are dropped
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			loop_half        <= `RST_LOOP_HALF;
			qcell            <= `RST_QCELL;
			steady_timer_set <= `RST_STEADY_SET;
			nominal_delay    <= `RST_NOMINAL;
			shift_amount_set <= `RST_SHIFT_SET;
			pulse_width      <= `RST_PULSE_WIDTH;
		end
		else if (wr_pend)
		begin
			case (wr_addr)
			`OFS_LOOP_HALF:   loop_half        <= at_least_one({1'b0, hwdata[CW-1:0]});
			`OFS_QCELL:       qcell            <= hwdata[CW-1:0];
			`OFS_STEADY_SET:  steady_timer_set <= hwdata[CW-1:0];
			`OFS_NOMINAL:     nominal_delay    <= hwdata[CW-1:0];
			`OFS_SHIFT_SET:   shift_amount_set <= hwdata[CW-1:0];
			`OFS_PULSE_WIDTH: pulse_width      <= at_least_one({1'b0, hwdata[CW-1:0]});
			default:          loop_half        <= loop_half;
			endcase
		end
	end
	// ============================================================
	// input edge detection
	reg  osc_q;
	reg  rd_q;
	reg  sel_q;
	wire osc_rise = osc_in & ~osc_q;
	wire rd_edge  = encoded_read_in & ~rd_q;
	wire sel_chg  = read_select ^ sel_q;
	// pin inputs are synchronous, so one stage suffices for edges
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			osc_q   <= 1'b0;
			rd_q    <= 1'b0;
			sel_q   <= 1'b0;
			osc_out <= 1'b1;
		end
		else
		begin
			osc_q   <= osc_in;
			rd_q    <= encoded_read_in;
			sel_q   <= read_select;
			osc_out <= ~osc_in;  // inverting stage of the oscillator
		end
	end
	// ============================================================
	// loop oscillator, stop and restart
	reg  [CW-1:0] vco_cnt;
	reg  [CW+3:0] stop_cnt;
	wire          ref_edge = read_select ? rd_edge : osc_rise;
	wire          pd_en    = read_select ? (~vco && vco_cnt <= qcell) : 1'b1;
	wire [31:0]   stop_prd = loop_half * `RCLK_HALVES * `STOP_RCLK_MAX;
	wire [CW+3:0] stop_lim = stop_prd[CW+3:0];
	wire          vco_end  = (vco_cnt == {{(CW-1){1'b0}}, 1'b1});
	wire          vco_rise = (loop_state == LOOP_RUN) &&
	                         ((ref_edge && pd_en) || (vco_end && !vco));
	wire          vco_fall = (loop_state == LOOP_RUN) && vco_end && vco && !vco_rise;
	// half period counter; a compared edge pulls the phase to now
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			loop_state <= LOOP_RUN;
			vco        <= 1'b0;
			vco_cnt    <= `RST_LOOP_HALF;
			stop_cnt   <= {(CW+4){1'b0}};
		end
		else
		begin
			case (loop_state)
			LOOP_RUN:
			begin
				if (sel_chg)
				begin
					loop_state <= LOOP_STOP;
					vco        <= 1'b0;
					stop_cnt   <= {(CW+4){1'b0}};
				end
				else if (vco_rise)
				begin
					vco     <= 1'b1;
					vco_cnt <= loop_half;
				end
				else if (vco_fall)
				begin
					vco     <= 1'b0;
					vco_cnt <= loop_half;
				end
				else
					vco_cnt <= vco_cnt - {{(CW-1){1'b0}}, 1'b1};
			end
			LOOP_STOP:
			begin
				stop_cnt <= stop_cnt + {{(CW+3){1'b0}}, 1'b1};
				// restart on the first edge of the new reference, or at the limit
				if (ref_edge || stop_cnt >= stop_lim - {{(CW+3){1'b0}}, 1'b1})
				begin
					loop_state <= LOOP_RUN;
					vco        <= 1'b1;
					vco_cnt    <= loop_half;
				end
			end
			default: loop_state <= LOOP_RUN;
			endcase
		end
	end
	// ============================================================
	// read clock divider and data separator windows
	reg hit;
	reg captured;
	// divider is held cleared while the loop is stopped
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			read_clock <= 1'b0;
		else if (loop_state == LOOP_STOP || (loop_state == LOOP_RUN && sel_chg))
			read_clock <= 1'b0;
		else if (vco_rise)
			read_clock <= ~read_clock;
	end

	// window closes on the loop falling edge, opposite the locking edge
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hit               <= 1'b0;
			captured          <= 1'b0;
			retimed_read_data <= 1'b0;
		end
		else if (loop_state == LOOP_STOP)
		begin
			hit               <= 1'b0;
			captured          <= 1'b0;
			retimed_read_data <= 1'b0;
		end
		else if (vco_fall)
		begin
			hit               <= rd_edge;
			captured          <= hit | rd_edge;
			// re-encoded pulse starts mid read clock half, ends on next rise
			retimed_read_data <= captured;
		end
		else
		begin
			if (rd_edge)
				hit <= 1'b1;
			if (vco_rise)
				retimed_read_data <= 1'b0;
		end
	end
	// ============================================================
	// steady pattern detector
	reg  [CW-1:0] steady_cnt;
	reg  [CW+1:0] hold_cnt;
	wire [CW+1:0] data_period = {2'b00, loop_half} << 2;
	// the timer is retriggered by each read pulse
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			steady_cnt          <= {CW{1'b0}};
			hold_cnt            <= {(CW+2){1'b0}};
			steady_pattern_flag <= 1'b0;
		end
		else
		begin
			if (rd_edge)
				steady_cnt <= steady_timer_set;
			else if (steady_cnt != {CW{1'b0}})
				steady_cnt <= steady_cnt - {{(CW-1){1'b0}}, 1'b1};
			if (hold_cnt != {(CW+2){1'b0}})
				hold_cnt <= hold_cnt - {{(CW+1){1'b0}}, 1'b1};
			if (rd_edge && steady_cnt != {CW{1'b0}} && read_select)
			begin
				if (!steady_pattern_flag)
					hold_cnt <= data_period;
				steady_pattern_flag <= 1'b1;
			end
			else if (steady_cnt == {CW{1'b0}} && hold_cnt == {(CW+2){1'b0}})
				steady_pattern_flag <= 1'b0;
		end
	end

	// ============================================================
	// write clock and precompensation
	reg  [CW-1:0] dly_cnt;
	reg  [CW-1:0] wid_cnt;
	reg           wr_q;
	reg  [CW:0]   sel_dly;
	wire          wr_edge = osc_rise & encoded_write_in & ~wr_q;

	// delay choice; both shift inputs low is illegal and treated as nominal
	always @*
	begin
		sel_dly = {1'b0, nominal_delay};
		if (shift_enable && !early_n && late_n)
			sel_dly = {1'b0, nominal_delay} - {1'b0, shift_amount_set};
		else if (shift_enable && early_n && !late_n)
			sel_dly = {1'b0, nominal_delay} + {1'b0, shift_amount_set};
	end

	// write clock toggles on each crystal rise
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			write_clock <= 1'b0;
			wr_q        <= 1'b0;
		end
		else if (osc_rise)
		begin
			write_clock <= ~write_clock;
			wr_q        <= encoded_write_in;
		end
	end

	// one pulse in flight; a new edge restarts the delay
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			dly_cnt         <= {CW{1'b0}};
			wid_cnt         <= {CW{1'b0}};
			comp_write_data <= 1'b0;
		end
		else
		begin
			if (wr_edge)
				dly_cnt <= at_least_one(sel_dly);
			else if (dly_cnt != {CW{1'b0}})
				dly_cnt <= dly_cnt - {{(CW-1){1'b0}}, 1'b1};
			if (dly_cnt == {{(CW-1){1'b0}}, 1'b1} && !wr_edge)
			begin
				comp_write_data <= 1'b1;
				wid_cnt         <= pulse_width;
			end
			else if (wid_cnt != {CW{1'b0}})
			begin
				wid_cnt <= wid_cnt - {{(CW-1){1'b0}}, 1'b1};
				if (wid_cnt == {{(CW-1){1'b0}}, 1'b1})
					comp_write_data <= 1'b0;
			end
		end
	end

endmodule // read_sync_write_precomp

/* File: verification/read_sync_chk.sv */
// Purpose: port assertions for read_sync_write_precomp
// Assumes: loop half and pulse width stay at reset values
// Notes:   bound to every instance of the block
`timescale 1ns/10ps
module read_sync_chk (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic osc_in,
	input wire logic osc_out,
	input wire logic encoded_read_in,
	input wire logic read_select,
	input wire logic read_clock,
	input wire logic retimed_read_data,
	input wire logic steady_pattern_flag,
	input wire logic write_clock,
	input wire logic comp_write_data
);
	// ========
	// one clock domain, so the defaults hold for all
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	a_osc_echo: assert property ($past(hresetn) |-> osc_out == !$past(osc_in))
		else $error("osc out not inverted");
	a_wclk_follow: assert property ($past(hresetn) && $rose(osc_in) |-> ##[1:3] $changed(write_clock))
		else $error("write clock missed osc edge");
	a_stop_clock: assert property ($changed(read_select) |-> ##[0:2] !read_clock)
		else $error("read clock not held on switch");
	a_stop_bound: assert property ($changed(read_select) |-> ##[1:50] $rose(read_clock))
		else $error("loop stopped too long");
	a_rclk_low: assert property ($fell(read_clock) && $stable(read_select) |-> !read_clock[*3])
		else $error("read clock low half short");
	// pulses near a switch may be lost, so only a running loop counts
	a_rdata_late: assert property ($rose(encoded_read_in) && read_select && $past(read_select, 16)
		&& (read_clock || $past(read_clock, 8)) |-> ##[1:34] $rose(retimed_read_data))
		else $error("read data late");
	a_rdata_width: assert property ($rose(retimed_read_data) |-> retimed_read_data[*4])
		else $error("read data pulse short");
	a_flag_hold: assert property ($rose(steady_pattern_flag) |-> steady_pattern_flag[*8])
		else $error("steady flag pulse short");
	a_cwd_width: assert property ($rose(comp_write_data) |-> comp_write_data[*2] ##1 !comp_write_data)
		else $error("write pulse width wrong");
endmodule // read_sync_chk

bind read_sync_write_precomp read_sync_chk u_chk (
	.hclk, .hresetn, .osc_in, .osc_out, .encoded_read_in, .read_select, .read_clock,
	.retimed_read_data, .steady_pattern_flag, .write_clock, .comp_write_data
);

/* File: verification/read_sync_partner.sv */
// Purpose: far side model, controller clock source and drive channel
// Assumes: stepped on hclk, 8 hclk for each osc_in period
// Notes:   read pulses are one hclk wide, one each loop period
`timescale 1ns/10ps
module read_sync_partner (
	input  wire logic hclk,
	input  wire logic rd_on,
	input  wire logic wr_go,
	input  wire logic write_clock,
	output logic      osc_in,
	output logic      encoded_read_in,
	output logic      encoded_write_in
);
	// ========
	// state
	logic [2:0] cnt = 3'h0;
	logic       wck_q = 1'b0;
	// logic clock in place of a crystal, free running so lock never starves
	always @(posedge hclk)
	begin
		cnt <= cnt + 3'h1;
		wck_q <= write_clock;
	end
	assign osc_in = cnt[2];
	assign encoded_read_in = rd_on && cnt == 3'h1;
	// write data moves only when write clock changes, one half cycle wide
	initial encoded_write_in = 1'b0;
	always @(posedge hclk)
		if (write_clock != wck_q)
			encoded_write_in <= wr_go && !encoded_write_in;
endmodule // read_sync_partner

/* File: verification/read_sync_write_precomp_tb.sv */
// Purpose: directed bench for read_sync_write_precomp
// Assumes: 10 MHz hclk, partner osc_in at 8 hclk a period
// Notes:   write latency is judged against a baseline run
`timescale 1ns/10ps
`include "read_sync_defs.vh"
module read_sync_write_precomp_tb;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata, q;
	logic        hreadyout, hresp, osc_in, osc_out, encoded_read_in;
	logic        read_clock, retimed_read_data, steady_pattern_flag;
	logic        encoded_write_in, write_clock, comp_write_data;
	logic        read_select = 1'b0;
	logic        shift_enable = 1'b0;
	logic        early_n = 1'b1;
	logic        late_n = 1'b1;
	logic        rd_on = 1'b0;
	logic        wr_go = 1'b0;
	logic        rd_q = 1'b0;
	logic        rc_q = 1'b0;
	int          n_errors = 0;
	int          checks = 0;
	int          cyc = 0;
	int          n_rd = 0;
	int          n_rc = 0;
	int          base, n;
	// both shift inputs low is never driven
	logic [2:0]  pc [5] = '{3'h3, 3'h7, 3'h5, 3'h6, 3'h2};
	int          off [5] = '{0, 0, -2, 2, 0};
	logic [15:0] rv [6] = '{`RST_LOOP_HALF, `RST_QCELL, `RST_STEADY_SET,
		`RST_NOMINAL, `RST_SHIFT_SET, `RST_PULSE_WIDTH};

	always #50 hclk = ~hclk;

	read_sync_write_precomp u_dut (
		.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp, .osc_in, .osc_out,
		.encoded_read_in, .read_select, .read_clock, .retimed_read_data,
		.steady_pattern_flag, .encoded_write_in, .shift_enable, .early_n,
		.late_n, .write_clock, .comp_write_data
	);
	read_sync_partner u_far (
		.hclk, .rd_on, .wr_go, .write_clock, .osc_in, .encoded_read_in, .encoded_write_in
	);

	// ========
	// edge counters and run limit; the edge counters use nonblocking so reads see one value
	always @(posedge hclk)
	begin
		cyc++;
		rd_q <= retimed_read_data;
		rc_q <= read_clock;
		if (retimed_read_data && !rd_q)
			n_rd <= n_rd + 1;
		if (read_clock && !rc_q)
			n_rc <= n_rc + 1;
		if (cyc == 20000)
		begin
			n_errors++;
			end_sim();
		end
	end

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e)
		begin
			n_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	task automatic idle(input int k);
		repeat (k) @(posedge hclk);
	endtask

	// single ahb transfer, address phase then data phase
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask

	// cycles from a write data rise to the compensated pulse
	task automatic lat(output int c);
		idle(20);
		wr_go <= 1'b1;
		@(posedge encoded_write_in);
		wr_go <= 1'b0;
		c = 0;
		while (comp_write_data !== 1'b1 && c < 60)
		begin
			@(posedge hclk);
			c++;
		end
	endtask

	task automatic end_sim;
		$display("counts: checks=%0d n_errors=%0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial
	begin
		idle(6);
		hresetn <= 1'b1;
		@(posedge hclk);
		for (int i = 0; i < 6; i++)
		begin
			bus(1'b0, 8'(i * 4), 32'h0, q);
			chk(q, {16'h0, rv[i]});
		end
		bus(1'b1, 8'h40, 32'hffff, q);
		bus(1'b0, 8'h40, 32'h0, q);
		chk(q, 32'h0);
		bus(1'b1, `OFS_QCELL, 32'h1_0003, q);
		bus(1'b0, `OFS_QCELL, 32'h0, q);
		chk(q, 32'h3);
		bus(1'b1, `OFS_QCELL, {16'h0, `RST_QCELL}, q);
		// a zero pulse width is raised to one cycle
		bus(1'b1, `OFS_PULSE_WIDTH, 32'h0, q);
		bus(1'b0, `OFS_PULSE_WIDTH, 32'h0, q);
		chk(q, 32'h1);
		bus(1'b1, `OFS_PULSE_WIDTH, {16'h0, `RST_PULSE_WIDTH}, q);
		$display("registers done");
		bus(1'b1, `OFS_SHIFT_SET, 32'h2, q);
		lat(base);
		// next osc rise is seven cycles on, one more cycle to see the pulse
		chk(32'(base), 32'(`RST_NOMINAL + 8));
		for (int i = 0; i < 5; i++)
		begin
			{shift_enable, early_n, late_n} <= pc[i];
			lat(n);
			chk(32'(n), 32'(base + off[i]));
		end
		bus(1'b1, `OFS_NOMINAL, 32'h6, q);
		lat(n);
		chk(32'(n), 32'(base + 2));
		$display("write shift done");
		rd_on <= 1'b1;
		idle(4);
		read_select <= 1'b1;
		idle(100);
		n = n_rd;
		idle(64);
		chk(32'(n_rd - n >= 6), 32'h1);
		chk({31'h0, steady_pattern_flag}, 32'h1);
		bus(1'b0, `OFS_STATUS, 32'h0, q);
		chk({30'h0, q[1:0]}, 32'h3);
		rd_on <= 1'b0;
		idle(80);
		chk({31'h0, steady_pattern_flag}, 32'h0);
		read_select <= 1'b0;
		idle(60);
		n = n_rc;
		idle(80);
		chk(32'(n_rc - n), 32'h5);
		bus(1'b0, `OFS_STATUS, 32'h0, q);
		chk({31'h0, q[2]}, 32'h0);
		$display("read link done");
		end_sim();
	end
endmodule // read_sync_write_precomp_tb
